//--- hw/facsc_core.sv
// Purpose: flash access gating for firmware and debug-port requests
// Assumes: one clock, synchronous active-high reset, one request at a time
// Notes: flash array itself is outside; this block decides and stalls
//
// Summary of operation
// - read lock bit 0 blocks debug reads of its block, 1 allows.
// - write/erase lock bit 0 blocks debug writes/erases, 1 allows.
// - lock bit n covers the nth 8K block; small part uses bits 3..0.
// - firmware at/above limit cannot touch flash below the limit.
// - code-move read from upper into lower partition returns 0x00.
// - firmware in the lower partition is never fenced by the limit.
// - limit address is the limit byte followed by a zero byte.
// - limit register takes only the first write after reset.
// - limit byte resets to 0x00, limit address 0x0000.
// - debug port may read/write/erase unlocked pages only.
// - debug port may always read security bytes and clear lock bits.
// - debug erase of unlocked security page restores all lock bytes.
// - locked security page only unlocks through full device erase.
// - reserved area refuses every access from every requester.
// - lock bytes never restrict firmware accesses.
// - firmware may read/write the security page but never erase it.
// - control bit 7 one-shot sense-amp off, bit 6 read every cycle.
// - software writes/erases need the write/erase enable bit.
// - scratchpad select steers software flash access to 128 bytes.
// - erase plus write enable turns a write into a page erase.
// - external-move writes go to RAM unless write enable is set.
// - erase sets page to 0xFF; byte write only clears bits.
// - cpu stalls while a firmware write or erase is in progress; debug ones leave it running.
`timescale 1ns/1ps
`default_nettype none
module facsc_core #(
	parameter bit SMALL_PART = 1'b0,
	parameter int WR_CYCLES = facsc_pkg::FACSC_WR_CYCLES,
	parameter int ER_CYCLES = facsc_pkg::FACSC_ER_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	// special-function register port
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// firmware requests
	input wire logic [15:0] cpu_pc,
	input wire logic cpu_code_rd,
	input wire logic cpu_xwr,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_rvalid,
	output logic xram_wr,
	output logic cpu_stall,
	// debug port requests
	input wire logic dbg_req,
	input wire facsc_pkg::facsc_op_t dbg_op,
	input wire logic [15:0] dbg_addr,
	input wire logic [7:0] dbg_wdata,
	output logic [7:0] dbg_rdata,
	output logic dbg_done,
	output logic dbg_refused,
	// flash array command port
	output logic fl_rd,
	output logic fl_wr,
	output logic fl_erase,
	output logic fl_erase_all,
	output logic fl_scratch,
	output logic [15:0] fl_addr,
	output logic [7:0] fl_wdata,
	input wire logic [7:0] fl_rdata,
	// security bytes as stored in the array
	input wire logic [7:0] read_lock,
	input wire logic [7:0] write_lock,
	// sense amplifier controls
	output logic sa_oneshot,
	output logic sa_always
);
	import facsc_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// lock bit of the 8K block holding an address
	function automatic logic lock_bit(input logic [7:0] lb,
			input logic [15:0] a);
		lock_bit = lb[a[15:13]];
	endfunction

	function automatic logic in_sec_page(input logic [15:0] a);
		logic [15:0] p;
		p = SMALL_PART ? FACSC_SEC_PAGE_32K : FACSC_SEC_PAGE_64K;
		in_sec_page = (a[15:9] == p[15:9]);
	endfunction

	function automatic logic in_reserved(input logic [15:0] a);
		in_reserved = !SMALL_PART && (a >= FACSC_RSV_BASE_64K);
	endfunction

	// scratchpad view folds the address onto its 128 bytes
	function automatic logic [15:0] steer_addr(input logic sps,
			input logic [15:0] a);
		steer_addr = sps ? (a & FACSC_SCRATCH_MASK) : a;
	endfunction

	// ------------------------------------------------------------
	// per-block lock view
	// ------------------------------------------------------------
	// blocks 7..4 are absent on the small part and read as locked
	// one open bit per 8K block keeps the address decode to one index
	logic [7:0] rd_open;
	logic [7:0] wr_open;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_blk
			assign rd_open[gi] = read_lock[gi] && (!SMALL_PART || gi < 4);
			assign wr_open[gi] = write_lock[gi] && (!SMALL_PART || gi < 4);
		end
	endgenerate

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] psc_reg;
	logic [7:0] fcr_reg;
	logic [7:0] alp_reg;
	logic alp_locked_reg;
	facsc_state_t state_reg;
	logic [15:0] cnt_reg;
	logic [15:0] access_limit_address;

	assign access_limit_address = {alp_reg, 8'h00};

	// program store and flash control registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			psc_reg <= FACSC_PSC_RST;
			fcr_reg <= FACSC_FCR_RST;
		end else if (sfr_wr) begin
			if (sfr_addr == FACSC_PSC_ADDR)
				psc_reg <= sfr_wdata & FACSC_PSC_MASK;
			if (sfr_addr == FACSC_FCR_ADDR)
				fcr_reg <= sfr_wdata & FACSC_FCR_MASK; // reserved read 0
		end
	end

	// the lock flag, not the value, closes the register, so a first
	// write of 0x00 still blocks later writes until the next reset
	// write-once limit; alignment left to software
	always_ff @(posedge mclk) begin
		if (srst) begin
			alp_reg <= FACSC_ALP_RST;
			alp_locked_reg <= 1'b0;
		end else if (sfr_wr && sfr_addr == FACSC_ALP_ADDR &&
				!alp_locked_reg) begin
			alp_reg <= sfr_wdata;
			alp_locked_reg <= 1'b1;
		end
	end

	// register read back
	// unmapped offsets read zero so stale data never leaks out
	always_ff @(posedge mclk) begin
		if (srst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				FACSC_PSC_ADDR: sfr_rdata <= psc_reg;
				FACSC_FCR_ADDR: sfr_rdata <= fcr_reg;
				FACSC_ALP_ADDR: sfr_rdata <= alp_reg;
				default: sfr_rdata <= 8'h00;
			endcase
		end
	end

	// sense amplifier modes
	// plain mirrors of the control bits; the array owns the timer itself
	always_ff @(posedge mclk) begin
		if (srst) begin
			sa_oneshot <= FACSC_FCR_RST[FACSC_OSE_BIT];
			sa_always <= FACSC_FCR_RST[FACSC_RAE_BIT];
		end else begin
			sa_oneshot <= fcr_reg[FACSC_OSE_BIT];
			sa_always <= fcr_reg[FACSC_RAE_BIT];
		end
	end

	// ------------------------------------------------------------
	// access decisions
	// ------------------------------------------------------------
	logic upper_pc;
	logic fw_below;
	logic fw_write_ok;
	logic fw_erase_ok;
	logic fw_read_ok;
	logic fw_to_flash;
	logic dbg_sec_byte;
	logic dbg_ok;

	// firmware decisions look only at the current request and registers;
	// the sequencer samples them in the request cycle.
	// scratchpad accesses skip the fence and the reserved check, as the
	// folded address always lands in the first 128 bytes.
	// lower-partition code is never fenced
	assign upper_pc = (cpu_pc >= access_limit_address);
	// lock bytes play no part here
	assign fw_below = upper_pc && (cpu_addr < access_limit_address) &&
		!psc_reg[FACSC_SPS_BIT];
	assign fw_to_flash = psc_reg[FACSC_PWE_BIT];
	assign fw_read_ok = !fw_below && (psc_reg[FACSC_SPS_BIT] ||
		!in_reserved(cpu_addr));
	assign fw_write_ok = fw_to_flash && fcr_reg[FACSC_WEE_BIT] &&
		fw_read_ok;
	// security page may be written, not erased
	assign fw_erase_ok = fw_write_ok && psc_reg[FACSC_PEE_BIT] &&
		(psc_reg[FACSC_SPS_BIT] || !in_sec_page(cpu_addr));

	assign dbg_sec_byte = in_sec_page(dbg_addr) && (dbg_addr[8:1] == 8'hff);

	// a refused request still answers, with dbg_refused, so the host
	// never waits on a blocked address; a full erase is never refused,
	// being the only way back from a locked security page
	// debug-port gating by lock bytes
	always_comb begin
		dbg_ok = 1'b0;
		case (dbg_op)
			// security bytes always readable
			FACSC_OP_READ: dbg_ok = dbg_sec_byte ||
				(!in_reserved(dbg_addr) &&
				lock_bit(rd_open, dbg_addr));
			// writing security bytes only clears bits, always allowed
			FACSC_OP_WRITE: dbg_ok = dbg_sec_byte ||
				(!in_reserved(dbg_addr) &&
				lock_bit(wr_open, dbg_addr));
			FACSC_OP_ERASE: dbg_ok = !in_reserved(dbg_addr) &&
				lock_bit(wr_open, dbg_addr);
			FACSC_OP_FULL: dbg_ok = 1'b1;
			default: dbg_ok = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// request sequencer and busy timer
	// ------------------------------------------------------------
	// one request at a time and debug wins a tie; while busy, new
	// requests are dropped, not queued. firmware stalls behind its own
	// programs, but a debug program leaves cpu_stall low, so firmware
	// must not write flash while a debug erase runs.
	// fl_rdata is taken in the request cycle: the array must answer
	// combinationally, a slower one would need a wait state here.
	// busy counts are cycle figures only; cell timing is the array's.
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= FACSC_IDLE;
			cnt_reg <= 16'h0000;
			cpu_stall <= 1'b0;
			fl_rd <= 1'b0;
			fl_wr <= 1'b0;
			fl_erase <= 1'b0;
			fl_erase_all <= 1'b0;
			fl_scratch <= 1'b0;
			fl_addr <= 16'h0000;
			fl_wdata <= FACSC_ERASED;
			xram_wr <= 1'b0;
			cpu_rvalid <= 1'b0;
			cpu_rdata <= 8'h00;
			dbg_done <= 1'b0;
			dbg_refused <= 1'b0;
			dbg_rdata <= 8'h00;
		end else begin
			fl_rd <= 1'b0;
			fl_wr <= 1'b0;
			fl_erase <= 1'b0;
			fl_erase_all <= 1'b0;
			xram_wr <= 1'b0;
			cpu_rvalid <= 1'b0;
			dbg_done <= 1'b0;
			dbg_refused <= 1'b0;
			case (state_reg)
				FACSC_IDLE: begin
					if (dbg_req) begin
						fl_addr <= dbg_addr;
						fl_scratch <= 1'b0;
						fl_wdata <= dbg_wdata;
						if (!dbg_ok) begin
							dbg_done <= 1'b1;
							dbg_refused <= 1'b1;
						end else if (dbg_op == FACSC_OP_READ) begin
							fl_rd <= 1'b1;
							dbg_done <= 1'b1;
							dbg_rdata <= fl_rdata;
						end else begin
							fl_wr <= (dbg_op == FACSC_OP_WRITE);
							fl_erase <= (dbg_op == FACSC_OP_ERASE);
							// full erase also clears lock bytes
							fl_erase_all <= (dbg_op == FACSC_OP_FULL);
							cnt_reg <= (dbg_op == FACSC_OP_WRITE) ?
								16'(WR_CYCLES) : 16'(ER_CYCLES);
							state_reg <= FACSC_BUSY;
						end
					end else if (cpu_code_rd) begin
						// scratchpad steering
						fl_scratch <= psc_reg[FACSC_SPS_BIT];
						fl_addr <= steer_addr(psc_reg[FACSC_SPS_BIT], cpu_addr);
						fl_rd <= fw_read_ok;
						cpu_rvalid <= 1'b1;
						cpu_rdata <= fw_read_ok ? fl_rdata :
							FACSC_BLOCKED_DATA;
					end else if (cpu_xwr) begin
						if (!fw_to_flash) begin
							xram_wr <= 1'b1;
						end else if (fw_write_ok && (!psc_reg[FACSC_PEE_BIT]
								|| fw_erase_ok)) begin
							fl_scratch <= psc_reg[FACSC_SPS_BIT];
							fl_addr <= steer_addr(psc_reg[FACSC_SPS_BIT], cpu_addr);
							fl_wdata <= cpu_wdata; // array ands into cell
							fl_erase <= psc_reg[FACSC_PEE_BIT]; // data ignored
							fl_wr <= !psc_reg[FACSC_PEE_BIT];
							cnt_reg <= psc_reg[FACSC_PEE_BIT] ?
								16'(ER_CYCLES) : 16'(WR_CYCLES);
							cpu_stall <= 1'b1;
							state_reg <= FACSC_BUSY;
						end
						// refused flash write: nothing issued
					end
				end
				FACSC_BUSY: begin
					if (cnt_reg <= 16'h0001) begin
						state_reg <= FACSC_IDLE;
						cpu_stall <= 1'b0;
						dbg_done <= !cpu_stall;
					end else begin
						cnt_reg <= cnt_reg - 16'h0001;
					end
				end
				default: state_reg <= FACSC_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- shared/facsc_pkg.sv
// Purpose: constants for the flash access security control block
// Assumes: 64K program flash with 512-byte pages and 8K lock blocks
// Notes: register offsets are special-function addresses
`default_nettype none
package facsc_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] FACSC_PSC_ADDR = 8'h8f;
	localparam logic [7:0] FACSC_FCR_ADDR = 8'hb7;
	// access limit has no printed offset; chosen here
	localparam logic [7:0] FACSC_ALP_ADDR = 8'hb8;
	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] FACSC_PSC_RST = 8'h00;
	localparam logic [7:0] FACSC_FCR_RST = 8'h80;
	localparam logic [7:0] FACSC_ALP_RST = 8'h00;
	localparam logic [7:0] FACSC_PSC_MASK = 8'h07;
	localparam logic [7:0] FACSC_FCR_MASK = 8'hc1;
	localparam int FACSC_PWE_BIT = 0;
	localparam int FACSC_PEE_BIT = 1;
	localparam int FACSC_SPS_BIT = 2;
	localparam int FACSC_WEE_BIT = 0;
	localparam int FACSC_RAE_BIT = 6;
	localparam int FACSC_OSE_BIT = 7;
	// ------------------------------------------------------------
	// memory map
	// ------------------------------------------------------------
	localparam logic [15:0] FACSC_SEC_PAGE_64K = 16'hfa00;
	localparam logic [15:0] FACSC_SEC_PAGE_32K = 16'h7e00;
	localparam logic [15:0] FACSC_RSV_BASE_64K = 16'hfc00;
	localparam logic [7:0] FACSC_LOCK_OPEN = 8'hff;
	localparam logic [7:0] FACSC_ERASED = 8'hff;
	localparam logic [7:0] FACSC_BLOCKED_DATA = 8'h00;
	localparam logic [15:0] FACSC_SCRATCH_MASK = 16'h007f;
	// program busy cycles (hardware timed; shortened default)
	localparam int FACSC_WR_CYCLES = 16;
	localparam int FACSC_ER_CYCLES = 64;
	typedef enum logic [1:0] {
		FACSC_IDLE = 2'b00,
		FACSC_BUSY = 2'b01
	} facsc_state_t;
	typedef enum logic [1:0] {
		FACSC_OP_READ = 2'b00,
		FACSC_OP_WRITE = 2'b01,
		FACSC_OP_ERASE = 2'b10,
		FACSC_OP_FULL = 2'b11
	} facsc_op_t;
endpackage
`default_nettype wire

//--- sim/facsc_core_monitor.sv
// Purpose: port checker for facsc_core
// Assumes: one clock, srst synchronous and active high
// Notes: shadows two enable bits from register writes
`timescale 1ns/1ps
`default_nettype none
module facsc_core_monitor (
	input wire logic mclk,
	input wire logic srst,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic cpu_xwr,
	input wire logic dbg_req,
	input wire facsc_pkg::facsc_op_t dbg_op,
	input wire logic xram_wr,
	input wire logic cpu_stall,
	input wire logic dbg_done,
	input wire logic dbg_refused,
	input wire logic fl_rd,
	input wire logic fl_wr,
	input wire logic fl_erase,
	input wire logic fl_erase_all,
	input wire logic fl_scratch,
	input wire logic [15:0] fl_addr,
	input wire logic sa_always
);
	import facsc_pkg::*;
	logic wee_reg, pwe_reg, go, fcr_wr, dbg_busy_reg, dbg_busy;
	// shadow enables so request outcomes can be predicted
	always_ff @(posedge mclk) begin
		if (srst) begin
			wee_reg <= 1'b0;
			pwe_reg <= 1'b0;
		end else if (fcr_wr) begin
			wee_reg <= sfr_wdata[FACSC_WEE_BIT];
		end else if (sfr_wr && sfr_addr == FACSC_PSC_ADDR) begin
			pwe_reg <= sfr_wdata[FACSC_PWE_BIT];
		end
	end
	// debug program/erase keeps the core busy with cpu_stall low
	always_ff @(posedge mclk) begin
		if (srst)
			dbg_busy_reg <= 1'b0;
		else
			dbg_busy_reg <= dbg_busy;
	end
	assign dbg_busy = (dbg_busy_reg && !dbg_done) ||
		((fl_wr || fl_erase || fl_erase_all) && !cpu_stall);
	// a write request the core must take (idle, debug absent)
	assign go = cpu_xwr && !cpu_stall && !dbg_busy && !dbg_req;
	assign fcr_wr = sfr_wr && sfr_addr == FACSC_FCR_ADDR;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// only a firmware program stalls the cpu; debug ones run beside it
	property p_stall_wr;
		(fl_wr || fl_erase) && !$past(dbg_req) |-> cpu_stall ##1 cpu_stall;
	endproperty
	a_stall_wr: assert property (p_stall_wr) else $error("no stall");
	property p_stall_end; $rose(cpu_stall) |-> ##[1:300] !cpu_stall; endproperty
	a_stall_end: assert property (p_stall_end) else $error("stall hangs");
	property p_no_wee; go && !wee_reg |=> !fl_wr && !fl_erase; endproperty
	a_no_wee: assert property (p_no_wee) else $error("write unenabled");
	property p_to_ram; go && !pwe_reg |=> xram_wr && !fl_wr; endproperty
	a_to_ram: assert property (p_to_ram) else $error("not to ram");
	property p_rsv;
		(fl_rd || fl_wr || fl_erase) && !fl_scratch |-> fl_addr < FACSC_RSV_BASE_64K;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved touched");
	property p_refuse; dbg_refused |-> dbg_done && !fl_rd && !fl_wr && !fl_erase; endproperty
	a_refuse: assert property (p_refuse) else $error("refusal acted");
	property p_dbg_rd;
		dbg_req && dbg_op == FACSC_OP_READ && !cpu_stall && !dbg_busy
			|=> dbg_done;
	endproperty
	a_dbg_rd: assert property (p_dbg_rd) else $error("read not done");
	// register updates at the write edge, the mirror one edge later
	property p_sa; $changed(sa_always) |-> $past(fcr_wr, 2); endproperty
	a_sa: assert property (p_sa) else $error("read mode moved");
	c_erase: cover property (fl_erase);
	c_refused: cover property (dbg_refused);
	c_ram: cover property (xram_wr);
endmodule
bind facsc_core facsc_core_monitor u_mon (.mclk, .srst, .sfr_wr, .sfr_addr,
	.sfr_wdata, .cpu_xwr, .dbg_req, .dbg_op, .xram_wr, .cpu_stall, .dbg_done,
	.dbg_refused, .fl_rd, .fl_wr, .fl_erase, .fl_erase_all, .fl_scratch,
	.fl_addr, .sa_always);
`default_nettype wire

//--- sim/facsc_flash_model.sv
// Purpose: flash array stand-in holding the two lock bytes
// Assumes: 64K map, lock bytes at the top of the security page
// Notes: reads return a fixed pattern; locks survive reset
`timescale 1ns/1ps
`default_nettype none
module facsc_flash_model (
	input wire logic mclk,
	input wire logic fl_wr,
	input wire logic fl_erase,
	input wire logic fl_erase_all,
	input wire logic [15:0] fl_addr,
	input wire logic [7:0] fl_wdata,
	output logic [7:0] fl_rdata,
	output logic [7:0] read_lock,
	output logic [7:0] write_lock
);
	import facsc_pkg::*;
	assign fl_rdata = 8'h5a;
	initial read_lock = 8'hff;
	initial write_lock = 8'hff;
	// erase sets bytes to ff, a write only clears bits
	always @(posedge mclk) begin
		if (fl_erase_all || (fl_erase && fl_addr[15:9] == 7'h7d)) begin
			read_lock <= 8'hff;
			write_lock <= 8'hff;
		end else if (fl_wr && fl_addr == 16'hfbfe) begin
			write_lock <= write_lock & fl_wdata;
		end else if (fl_wr && fl_addr == 16'hfbff) begin
			read_lock <= read_lock & fl_wdata;
		end
	end
endmodule
`default_nettype wire

//--- sim/test_flash_access_security_control.sv
// Purpose: directed bench for facsc_core
// Assumes: short program counts, inputs driven on falling edges
// Notes: output pulses are tallied so tasks judge deltas
`timescale 1ns/1ps
`default_nettype none
module test_flash_access_security_control;
	import facsc_pkg::*;
	logic mclk = 1'b0, srst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic cpu_code_rd = 1'b0, cpu_xwr = 1'b0, dbg_req = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, cpu_wdata = 8'h3c;
	logic [7:0] dbg_wdata = 8'h00, sfr_rdata, cpu_rdata, dbg_rdata, fl_wdata;
	logic [7:0] fl_rdata, read_lock, write_lock;
	logic [15:0] cpu_pc = 16'h0000, cpu_addr = 16'h0000, dbg_addr = 16'h0000;
	logic [15:0] fl_addr;
	facsc_op_t dbg_op = FACSC_OP_READ;
	logic cpu_rvalid, xram_wr, cpu_stall, dbg_done, dbg_refused, fl_rd, fl_wr;
	logic fl_erase, fl_erase_all, fl_scratch, sa_oneshot, sa_always;
	int failures = 0, compares = 0, n_wr = 0, n_er = 0, n_xr = 0, n_rf = 0, n_dn = 0;
	always #5 mclk = ~mclk;
	facsc_core #(.WR_CYCLES(2), .ER_CYCLES(4)) u_dut (.mclk, .srst, .sfr_wr,
		.sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .cpu_pc, .cpu_code_rd,
		.cpu_xwr, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_rvalid, .xram_wr,
		.cpu_stall, .dbg_req, .dbg_op, .dbg_addr, .dbg_wdata, .dbg_rdata,
		.dbg_done, .dbg_refused, .fl_rd, .fl_wr, .fl_erase, .fl_erase_all,
		.fl_scratch, .fl_addr, .fl_wdata, .fl_rdata, .read_lock, .write_lock,
		.sa_oneshot, .sa_always);
	facsc_flash_model u_flash (.mclk, .fl_wr, .fl_erase, .fl_erase_all,
		.fl_addr, .fl_wdata, .fl_rdata, .read_lock, .write_lock);
	// tally one-cycle pulses so they cannot slip past a task
	always @(posedge mclk) begin
		n_wr += int'(fl_wr);
		n_er += int'(fl_erase);
		n_xr += int'(xram_wr);
		n_rf += int'(dbg_refused);
		n_dn += int'(dbg_done);
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_wr = w;
		sfr_rd = !w;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge mclk);
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	endtask
	// reads judge the data, writes judge {ram, erase, flash} pulse counts
	task automatic cpu(input logic rd, input logic [15:0] pc, input logic [15:0] a,
		input logic [15:0] exp);
		int x0, e0, w0;
		x0 = n_xr;
		e0 = n_er;
		w0 = n_wr;
		@(negedge mclk);
		cpu_code_rd = rd;
		cpu_xwr = !rd;
		cpu_pc = pc;
		cpu_addr = a;
		@(negedge mclk);
		cpu_code_rd = 1'b0;
		cpu_xwr = 1'b0;
		if (rd) check({8'h00, cpu_rdata}, exp);
		if (rd) check({15'h0000, cpu_rvalid}, 16'h0001);
		for (int i = 0; i < 300 && cpu_stall !== 1'b0; i++) @(negedge mclk);
		check({15'h0000, cpu_stall}, 16'h0000);
		@(negedge mclk);
		if (!rd) check(16'((n_xr - x0) * 256 + (n_er - e0) * 16 + n_wr - w0),
			exp);
	endtask
	// judges {refused count, read data when allowed}
	task automatic dbg(input facsc_op_t op, input logic [15:0] a,
		input logic [7:0] d, input logic [15:0] exp);
		int r0, d0;
		logic [15:0] v;
		r0 = n_rf;
		d0 = n_dn;
		@(negedge mclk);
		dbg_req = 1'b1;
		dbg_op = op;
		dbg_addr = a;
		dbg_wdata = d;
		@(negedge mclk);
		dbg_req = 1'b0;
		for (int i = 0; i < 300 && n_dn == d0; i++) @(negedge mclk);
		check(16'(n_dn - d0), 16'h0001);
		v = 16'((n_rf - r0) * 256);
		if (op == FACSC_OP_READ && n_rf == r0) v = {8'h00, dbg_rdata};
		check(v, exp);
		@(negedge mclk);
	endtask
	task automatic t_regs;
		logic [7:0] a[4] = '{8'h8f, 8'hb7, 8'hb8, 8'ha0};
		logic [7:0] e[4] = '{8'h00, 8'h80, 8'h00, 8'h00};
		for (int i = 0; i < 4; i++) begin
			sfr(1'b0, a[i], 8'h00);
			check({8'h00, sfr_rdata}, {8'h00, e[i]});
		end
		check({14'h0000, sa_oneshot, sa_always}, 16'h0002);
		sfr(1'b1, 8'hb7, 8'h7f);
		// reserved bits read back as zero; the read also lets the mirror settle
		sfr(1'b0, 8'hb7, 8'h00);
		check({8'h00, sfr_rdata}, 16'h0041);
		check({14'h0000, sa_oneshot, sa_always}, 16'h0001);
		sfr(1'b1, 8'hb7, 8'h81);
		$display("t_regs done");
	endtask
	task automatic t_limit;
		sfr(1'b1, 8'hb8, 8'h40);
		sfr(1'b1, 8'hb8, 8'h80);
		sfr(1'b0, 8'hb8, 8'h00);
		check({8'h00, sfr_rdata}, 16'h0040);
		cpu(1'b1, 16'h5000, 16'h3fff, 16'h0000);
		cpu(1'b1, 16'h4000, 16'h4000, 16'h005a);
		cpu(1'b1, 16'h1000, 16'h3fff, 16'h005a);
		$display("t_limit done");
	endtask
	task automatic t_fw;
		cpu(1'b0, 16'h5000, 16'h6000, 16'h0100);
		sfr(1'b1, 8'h8f, 8'h01);
		cpu(1'b0, 16'h5000, 16'h6000, 16'h0001);
		cpu(1'b0, 16'h5000, 16'h1000, 16'h0000);
		cpu(1'b0, 16'h1000, 16'h4200, 16'h0001);
		sfr(1'b1, 8'hb7, 8'h80);
		cpu(1'b0, 16'h5000, 16'h6000, 16'h0000);
		sfr(1'b1, 8'hb7, 8'h81);
		sfr(1'b1, 8'h8f, 8'h03);
		cpu(1'b0, 16'h5000, 16'h6100, 16'h0010);
		cpu(1'b0, 16'h5000, 16'hfa00, 16'h0000);
		cpu(1'b0, 16'h5000, 16'hfc00, 16'h0000);
		sfr(1'b1, 8'h8f, 8'h05);
		cpu(1'b0, 16'h5000, 16'h0010, 16'h0001);
		check(fl_addr, 16'h0010);
		check({15'h0000, fl_scratch}, 16'h0001);
		sfr(1'b1, 8'h8f, 8'h01);
		$display("t_fw done");
	endtask
	task automatic t_dbg;
		dbg(FACSC_OP_WRITE, 16'hfbfe, 8'hfe, 16'h0000);
		dbg(FACSC_OP_WRITE, 16'h0100, 8'h00, 16'h0100);
		dbg(FACSC_OP_READ, 16'h0100, 8'h00, 16'h005a);
		dbg(FACSC_OP_WRITE, 16'hfbff, 8'h7d, 16'h0000);
		dbg(FACSC_OP_READ, 16'h2000, 8'h00, 16'h0100);
		dbg(FACSC_OP_READ, 16'h1fff, 8'h00, 16'h005a);
		dbg(FACSC_OP_READ, 16'hfbff, 8'h00, 16'h005a);
		dbg(FACSC_OP_READ, 16'hfc00, 8'h00, 16'h0100);
		cpu(1'b0, 16'h1000, 16'h0100, 16'h0001);
		dbg(FACSC_OP_ERASE, 16'hfa00, 8'h00, 16'h0000);
		dbg(FACSC_OP_WRITE, 16'h0100, 8'h00, 16'h0000);
		dbg(FACSC_OP_WRITE, 16'hfbfe, 8'h7f, 16'h0000);
		dbg(FACSC_OP_ERASE, 16'hfa00, 8'h00, 16'h0100);
		dbg(FACSC_OP_FULL, 16'hfbfe, 8'h00, 16'h0000);
		dbg(FACSC_OP_ERASE, 16'hfa00, 8'h00, 16'h0000);
		$display("t_dbg done");
	endtask
	task automatic end_of_test;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		srst = 1'b0;
		t_regs();
		t_limit();
		t_fw();
		t_dbg();
		end_of_test();
	end
	// about 160 cycles expected; cut off at 20000
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire
